/* File: common/timer_pkg.sv */
// Shared constants for the dual timer/counter with clock-out
package timer_pkg;

  // ==========================================================
  // Operating mode encodings of the two mode-select bits
  localparam logic [1:0] MODE_13BIT   = 2'h0;
  localparam logic [1:0] MODE_16BIT   = 2'h1;
  localparam logic [1:0] MODE_RELOAD8 = 2'h2;
  localparam logic [1:0] MODE_SPLIT   = 2'h3;

  // ==========================================================
  // Count layout and reset values
  localparam int         BYTE_W       = 8;
  localparam int         LOW13_BITS   = 5;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [7:0] BYTE_ONES    = 8'hff;
  localparam logic [4:0] LOW13_ONES   = 5'h1f;
  localparam logic [4:0] LOW13_STEP   = 5'h01;
  localparam logic [7:0] BYTE_STEP    = 8'h01;
  localparam logic [16:0] WORD_STEP   = 17'h0_0001;

  // ==========================================================
  // Timing: slow rate is one count per machine cycle
  localparam int         PRESCALE_DIV = 12;

  // ==========================================================
  // Timer indices
  localparam int         T0           = 0;
  localparam int         T1           = 1;

endpackage

/* File: rtl/timer_rate_gen.sv */
// Rate cycle generator and count-pin falling edge sampler for one timer
`timescale 1ns/10ps
module timer_rate_gen #(
  parameter int PRESCALE = timer_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic clk_en,
  // Configuration
  input  wire logic fast_clock_select,
  input  wire logic counter_select,
  // External count input
  input  wire logic count_pin,
  // Results
  output logic      rate_tick,
  output logic      count_inc
);

  localparam int CW = $clog2(PRESCALE);
  localparam logic [CW-1:0] LAST = CW'(PRESCALE - 1);
  localparam logic [CW-1:0] ZERO = '0;

  // ==========================================================
  // Parameter check
  generate
    if (PRESCALE < 2) begin : g_bad
      $error("PRESCALE must be at least 2");
    end
  endgenerate

  logic [CW-1:0] div_r;
  logic          sample_r;
  logic          event_r;

  // ==========================================================
  // Prescaler
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= ZERO;
    end else if (clk_en) begin
      if (div_r == LAST) begin
        div_r <= ZERO;
      end else begin
        div_r <= div_r + CW'(1);
      end
    end
  end

  // Fast select gives a rate cycle on every clock
  assign rate_tick = clk_en
    && (fast_clock_select || div_r == LAST); // RULE1 RULE2

  // ==========================================================
  // Pin sampled once per rate cycle; a high then low pair is held
  // until the next rate cycle, where the count is applied
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sample_r <= 1'b0;
      event_r  <= 1'b0;
    end else if (rate_tick) begin
      sample_r <= count_pin; // RULE4
      event_r  <= sample_r && !count_pin; // RULE3 RULE4
    end
  end

  assign count_inc = rate_tick && (!counter_select || event_r); // RULE5

endmodule

/* File: rtl/dual_timer_counter_clockout.sv */
// Two timer/counter units with split mode and programmable clock-out
//
// Notes on behaviour
// RULE1 - Timer function steps once per 12 system clocks, fast select clear.
// RULE2 - Fast select set makes the timer count on every system clock.
// RULE3 - Counter function counts falling edges on the count pin.
// RULE4 - Count pin sampled once per rate cycle; high then low counts.
// RULE5 - Detected edge shows in the count at end of the next rate cycle.
// RULE6 - Mode 0 is a 13-bit counter; rollover sets the overflow flag.
// RULE7 - Counting needs run bit and either gating off or gating pin high.
// RULE8 - Mode 1 counts all 16 bits; rollover sets the overflow flag.
// RULE9 - Mode 2 low byte counts, overflow sets flag and reloads from high.
// RULE10 - Timer 1 in mode 3 stops and holds its count.
// RULE11 - Timer 0 mode 3 low byte is an 8-bit counter with timer 0 controls.
// RULE12 - Timer 0 mode 3 high byte times only, uses timer 1 run and flag.
// RULE13 - Clock-out mode: 8-bit reload, pin toggles on every overflow.
// RULE14 - Clock-out frequency is clock over n times (256 minus reload).
// RULE15 - Clock-out overflow sets the flag but raises no interrupt request.
// RULE16 - Timer 1 overflow serves baud rate and clock-out at once.
// RULE17 - Software sets up clock-out, loads both bytes, then sets run.
// RULE18 - Mode bits: 00 13-bit, 01 16-bit, 10 reload, 11 split/stop.
// RULE19 - Flag cleared on interrupt vectoring; software may set or clear it.
// RULE20 - Mode 0 uses high byte above the low five bits of low byte.
`timescale 1ns/10ps
module dual_timer_counter_clockout #(
  parameter int PRESCALE = timer_pkg::PRESCALE_DIV
) (
  // Clock, reset and enable
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  // Mode control, index 0 is timer 0
  input  wire logic [1:0] gate_enable,
  input  wire logic [1:0] counter_select,
  input  wire logic [1:0] mode_select_high,
  input  wire logic [1:0] mode_select_low,
  input  wire logic [1:0] run_control,
  // Clock source and clock-out control
  input  wire logic       timer0_fast_clock_select,
  input  wire logic       timer1_fast_clock_select,
  input  wire logic       timer0_clockout_enable,
  input  wire logic       timer1_clockout_enable,
  // External pins
  input  wire logic [1:0] count_pin,
  input  wire logic [1:0] gating_interrupt_pin,
  // Software writes of count bytes
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] count_low_byte_wr,
  input  wire logic [1:0] count_high_byte_reload_wr,
  // Software flag access and interrupt vectoring
  input  wire logic [1:0] flag_wr,
  input  wire logic [1:0] flag_wr_value,
  input  wire logic [1:0] vector_ack,
  // Count state
  output logic      [7:0] timer0_low_byte,
  output logic      [7:0] timer0_high_byte,
  output logic      [7:0] timer1_low_byte,
  output logic      [7:0] timer1_high_byte,
  // Flags and requests
  output logic      [1:0] overflow_flag,
  output logic      [1:0] timer_irq,
  output logic            timer1_overflow_pulse,
  // Clock-out pins
  output logic            timer0_clockout_pin,
  output logic            timer1_clockout_pin
);

  localparam int T0 = timer_pkg::T0;
  localparam int T1 = timer_pkg::T1;

  // ==========================================================
  // Parameter check
  generate
    if (PRESCALE < 2) begin : g_bad
      $error("PRESCALE must be at least 2");
    end
  endgenerate

  // ==========================================================
  // One count step: returns {overflow, high, low}
  function automatic logic [16:0] count_step(
    input logic [1:0] mode,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic       ovf;
    logic [7:0] nhi;
    logic [7:0] nlo;
    begin
      ovf = 1'b0;
      nhi = hi;
      nlo = lo;
      case (mode)
        timer_pkg::MODE_13BIT: begin
          // Upper three low-byte bits are left alone
          nlo[4:0] = lo[4:0] + timer_pkg::LOW13_STEP; // RULE20
          if (lo[4:0] == timer_pkg::LOW13_ONES) begin
            nhi = hi + timer_pkg::BYTE_STEP;
            ovf = (hi == timer_pkg::BYTE_ONES); // RULE6
          end
        end
        timer_pkg::MODE_16BIT: begin
          {ovf, nhi, nlo} = {1'b0, hi, lo} + timer_pkg::WORD_STEP; // RULE8
        end
        timer_pkg::MODE_RELOAD8: begin
          if (lo == timer_pkg::BYTE_ONES) begin
            nlo = hi; // RULE9
            ovf = 1'b1;
          end else begin
            nlo = lo + timer_pkg::BYTE_STEP;
          end
        end
        default: begin
          // Split low byte: free 8-bit wrap
          nlo = lo + timer_pkg::BYTE_STEP; // RULE11
          ovf = (lo == timer_pkg::BYTE_ONES);
        end
      endcase
      count_step = {ovf, nhi, nlo};
    end
  endfunction

  // ==========================================================
  // Rate cycles and count events
  logic [1:0] rate_tick;
  logic [1:0] count_inc;

  timer_rate_gen #(
    .PRESCALE          (PRESCALE)
  ) u_rate0 (
    .clk_sys           (clk_sys),
    .arst_n            (arst_n),
    .clk_en            (clk_en),
    .fast_clock_select (timer0_fast_clock_select),
    .counter_select    (counter_select[T0]),
    .count_pin         (count_pin[T0]),
    .rate_tick         (rate_tick[T0]),
    .count_inc         (count_inc[T0])
  );

  timer_rate_gen #(
    .PRESCALE          (PRESCALE)
  ) u_rate1 (
    .clk_sys           (clk_sys),
    .arst_n            (arst_n),
    .clk_en            (clk_en),
    .fast_clock_select (timer1_fast_clock_select),
    .counter_select    (counter_select[T1]),
    .count_pin         (count_pin[T1]),
    .rate_tick         (rate_tick[T1]),
    .count_inc         (count_inc[T1])
  );

  // ==========================================================
  // Mode decode
  logic [1:0] mode_sel [2];
  logic [1:0] mode_eff [2];
  logic [1:0] clockout_on;
  logic [1:0] gate_open;
  logic       split0;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode_sel[i] = {mode_select_high[i], mode_select_low[i]}; // RULE18
    end
  end

  // Clock-out needs the timer function
  assign clockout_on[T0] = timer0_clockout_enable && !counter_select[T0];
  assign clockout_on[T1] = timer1_clockout_enable && !counter_select[T1];

  // Clock-out overrides the mode bits with 8-bit auto-reload
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode_eff[i] = clockout_on[i] ? timer_pkg::MODE_RELOAD8 // RULE13
                                   : mode_sel[i];
    end
  end

  assign split0 = (mode_eff[T0] == timer_pkg::MODE_SPLIT);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      gate_open[i] = run_control[i]
                     && (!gate_enable[i] || gating_interrupt_pin[i]); // RULE7
    end
  end

  // ==========================================================
  // Count enables
  logic t0_low_en;
  logic t0_high_en;
  logic t1_en;
  logic t1_holds;

  assign t0_low_en  = gate_open[T0] && count_inc[T0]; // RULE7 RULE11
  // Split high byte sees only internal rate cycles
  assign t0_high_en = split0 && run_control[T1] && rate_tick[T0]; // RULE12
  assign t1_holds   = (mode_eff[T1] == timer_pkg::MODE_SPLIT); // RULE10
  // While timer 0 owns the run bit, timer 1 runs on with no flag
  assign t1_en      = !t1_holds && count_inc[T1]
                      && (split0 || gate_open[T1]);

  // ==========================================================
  // Next counts
  logic [7:0]  low_r  [2];
  logic [7:0]  high_r [2];
  logic [16:0] step0;
  logic [16:0] step1;
  logic [7:0]  high0_inc;
  logic        ovf0;
  logic        ovf0_high;
  logic        ovf1;

  assign step0     = count_step(mode_eff[T0], high_r[T0], low_r[T0]);
  assign step1     = count_step(mode_eff[T1], high_r[T1], low_r[T1]);
  assign high0_inc = high_r[T0] + timer_pkg::BYTE_STEP;
  assign ovf0      = t0_low_en && step0[16];
  assign ovf0_high = t0_high_en && (high_r[T0] == timer_pkg::BYTE_ONES);
  assign ovf1      = t1_en && step1[16];

  // ==========================================================
  // Timer 0 low byte; a software write wins over a count
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      low_r[T0] <= timer_pkg::BYTE_RESET;
    end else if (clk_en) begin
      if (count_low_byte_wr[T0]) begin
        low_r[T0] <= wr_data;
      end else if (t0_low_en) begin
        low_r[T0] <= step0[7:0];
      end
    end
  end

  // ==========================================================
  // Timer 0 high byte
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      high_r[T0] <= timer_pkg::BYTE_RESET;
    end else if (clk_en) begin
      if (count_high_byte_reload_wr[T0]) begin
        high_r[T0] <= wr_data;
      end else if (t0_high_en) begin
        high_r[T0] <= high0_inc; // RULE12
      end else if (t0_low_en && !split0) begin
        high_r[T0] <= step0[15:8];
      end
    end
  end

  // ==========================================================
  // Timer 1 bytes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      low_r[T1] <= timer_pkg::BYTE_RESET;
    end else if (clk_en) begin
      if (count_low_byte_wr[T1]) begin
        low_r[T1] <= wr_data;
      end else if (t1_en) begin
        low_r[T1] <= step1[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      high_r[T1] <= timer_pkg::BYTE_RESET;
    end else if (clk_en) begin
      if (count_high_byte_reload_wr[T1]) begin
        high_r[T1] <= wr_data;
      end else if (t1_en) begin
        high_r[T1] <= step1[15:8];
      end
    end
  end

  assign timer0_low_byte  = low_r[T0];
  assign timer0_high_byte = high_r[T0];
  assign timer1_low_byte  = low_r[T1];
  assign timer1_high_byte = high_r[T1];

  // ==========================================================
  // Overflow flags: a hardware set beats a clear in the same cycle
  logic [1:0] flag_set;
  logic [1:0] flag_r;

  assign flag_set[T0] = ovf0; // RULE6 RULE8 RULE9
  // Timer 1 flag belongs to the split high byte in timer 0 mode 3
  assign flag_set[T1] = split0 ? ovf0_high : ovf1; // RULE12

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 2'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (flag_set[i]) begin
          flag_r[i] <= 1'b1;
        end else if (flag_wr[i]) begin
          flag_r[i] <= flag_wr_value[i]; // RULE19
        end else if (vector_ack[i]) begin
          flag_r[i] <= 1'b0; // RULE19
        end
      end
    end
  end

  assign overflow_flag = flag_r;

  // ==========================================================
  // Interrupt requests follow the flags except in clock-out mode
  logic [1:0] irq_mask;
  logic [1:0] irq_r;

  assign irq_mask[T0] = clockout_on[T0]; // RULE15
  assign irq_mask[T1] = clockout_on[T1] && !split0; // RULE15

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 2'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        irq_r[i] <= (flag_r[i] || flag_set[i]) && !irq_mask[i]
                    && !vector_ack[i];
      end
    end
  end

  assign timer_irq = irq_r;

  // ==========================================================
  // Timer 1 overflow for the baud-rate user, kept even in clock-out
  logic ovf1_pulse_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovf1_pulse_r <= 1'b0;
    end else begin
      ovf1_pulse_r <= clk_en && ovf1; // RULE16
    end
  end

  assign timer1_overflow_pulse = ovf1_pulse_r;

  // ==========================================================
  // Clock-out: one toggle per overflow gives 50% duty at
  // clock / (2 * rate * (256 - reload)), so n is 24 or 2
  logic [1:0] cko_r;
  logic [1:0] cko_ovf;

  assign cko_ovf[T0] = ovf0;
  assign cko_ovf[T1] = ovf1;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cko_r <= 2'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (!clockout_on[i]) begin
          cko_r[i] <= 1'b0;
        end else if (cko_ovf[i]) begin
          cko_r[i] <= !cko_r[i]; // RULE13 RULE14 RULE16
        end
      end
    end
  end

  assign timer0_clockout_pin = cko_r[T0];
  assign timer1_clockout_pin = cko_r[T1];

endmodule

/* File: testbench/timer_sva.sv */
// Checker for the dual timer/counter with clock-out
`timescale 1ns/10ps
module timer_chk #(
  parameter int PRESCALE = timer_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       clk_en,
  // Controls
  input wire logic [1:0] gate_enable,
  input wire logic [1:0] counter_select,
  input wire logic [1:0] mode_select_high,
  input wire logic [1:0] mode_select_low,
  input wire logic [1:0] run_control,
  input wire logic       timer0_fast_clock_select,
  input wire logic       timer0_clockout_enable,
  input wire logic       timer1_clockout_enable,
  input wire logic [1:0] gating_interrupt_pin,
  input wire logic [1:0] count_low_byte_wr,
  input wire logic [1:0] count_high_byte_reload_wr,
  input wire logic [1:0] flag_wr,
  input wire logic [1:0] vector_ack,
  // Observed state
  input wire logic [7:0] timer0_low_byte,
  input wire logic [7:0] timer0_high_byte,
  input wire logic [7:0] timer1_low_byte,
  input wire logic [7:0] timer1_high_byte,
  input wire logic [1:0] overflow_flag,
  input wire logic [1:0] timer_irq,
  input wire logic       timer1_clockout_pin
);
  // ==========================================================
  // Helper terms
  logic [1:0] m0, m1;
  logic       nw0, nw1, run16, steady;
  logic [7:0] tl_q;
  logic [7:0] gap_r;
  logic       valid_r;
  logic       steady_q;
  assign m0 = {mode_select_high[0], mode_select_low[0]};
  assign m1 = {mode_select_high[1], mode_select_low[1]};
  assign nw0 = clk_en && !count_low_byte_wr[0]
    && !count_high_byte_reload_wr[0];
  assign nw1 = clk_en && !count_low_byte_wr[1]
    && !count_high_byte_reload_wr[1];
  assign run16 = nw0 && run_control[0] && !gate_enable[0] && !counter_select[0]
                 && !timer0_clockout_enable && m0 == timer_pkg::MODE_16BIT;
  assign steady = run16 && !timer0_fast_clock_select;

  // Cycles since the last slow-rate step, valid only while steady
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tl_q    <= 8'h00;
      gap_r   <= 8'h00;
      valid_r <= 1'b0;
      steady_q <= 1'b0;
    end else begin
      tl_q <= timer0_low_byte;
      steady_q <= steady;
      if (timer0_low_byte != tl_q) begin
        gap_r   <= 8'h00;
        valid_r <= steady && steady_q;
      end else begin
        gap_r   <= gap_r + 8'h01;
        valid_r <= valid_r && steady;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Properties
  run_hold_a: assert property ((nw0 && !run_control[0])[*2] |=>
    $stable(timer0_low_byte)) else $error("count moved with run off");
  gate_hold_a: assert property ((nw0 && gate_enable[0] &&
    !gating_interrupt_pin[0])[*2] |=> $stable(timer0_low_byte))
    else $error("count moved while gated");
  t1_stop_a: assert property ((nw1 && m1 == timer_pkg::MODE_SPLIT &&
    m0 != timer_pkg::MODE_SPLIT && !timer1_clockout_enable)[*2] |=>
    $stable({timer1_high_byte, timer1_low_byte}))
    else $error("timer 1 moved in mode 3");
  reload_a: assert property ((nw0 && m0 == timer_pkg::MODE_RELOAD8 &&
    timer0_low_byte == 8'hff) ##1 (timer0_low_byte != 8'hff) |->
    timer0_low_byte == timer0_high_byte && overflow_flag[0])
    else $error("reload or flag wrong");
  fast_step_a: assert property ((run16 &&
    timer0_fast_clock_select)[*3] |=>
    timer0_low_byte == $past(timer0_low_byte) + 8'h01)
    else $error("fast rate step wrong");
  slow_gap_a: assert property (steady && valid_r &&
    timer0_low_byte != tl_q |-> gap_r == 8'(PRESCALE - 1))
    else $error("slow rate spacing wrong");
  irq_mask_a: assert property ((clk_en && timer1_clockout_enable &&
    !counter_select[1] && m0 != timer_pkg::MODE_SPLIT)[*2] |-> !timer_irq[1])
    else $error("request during clock-out");
  pin_idle_a: assert property ((clk_en && (!timer1_clockout_enable ||
    counter_select[1]))[*2] |-> !timer1_clockout_pin)
    else $error("clock-out pin active while off");
  ack_clr_a: assert property ((!run_control[0])[*2] ##0 (clk_en &&
    vector_ack[0] && !flag_wr[0]) |=> !overflow_flag[0])
    else $error("flag not cleared by vectoring");
  mode0_top_a: assert property ((nw0 && !timer0_clockout_enable &&
    m0 == timer_pkg::MODE_13BIT)[*2] |=> $stable(timer0_low_byte[7:5]))
    else $error("unused low bits moved");
endmodule

bind dual_timer_counter_clockout timer_chk #(.PRESCALE(PRESCALE)) u_chk (
  .clk_sys, .arst_n, .clk_en, .gate_enable, .counter_select,
  .mode_select_high, .mode_select_low, .run_control,
  .timer0_fast_clock_select, .timer0_clockout_enable,
  .timer1_clockout_enable, .gating_interrupt_pin, .count_low_byte_wr,
  .count_high_byte_reload_wr, .flag_wr, .vector_ack, .timer0_low_byte,
  .timer0_high_byte, .timer1_low_byte, .timer1_high_byte, .overflow_flag,
  .timer_irq, .timer1_clockout_pin
);

/* File: testbench/pin_model.sv */
// External count pins and gating pins seen by the timers
`timescale 1ns/10ps
module pin_model (
  // Clock
  input wire logic       clk_sys,
  // Requests from the bench
  input wire logic [1:0] edge_req,
  input wire logic [1:0] gate_lvl,
  // Pins
  output logic     [1:0] count_pin,
  output logic     [1:0] gating_interrupt_pin
);
  logic [2:0] low_cnt [2];

  // ==========================================================
  // Pins idle high; a request gives a three-cycle low pulse
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (edge_req[i])
        low_cnt[i] <= 3'h3;
      else if (low_cnt[i] != 3'h0)
        low_cnt[i] <= low_cnt[i] - 3'h1;
      count_pin[i] <= !(edge_req[i] || low_cnt[i] > 3'h1);
      gating_interrupt_pin[i] <= gate_lvl[i];
    end
  end

  initial begin
    low_cnt[0] = 3'h0;
    low_cnt[1] = 3'h0;
  end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the dual timer/counter with clock-out
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  err_count++; $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb;
  localparam int PRE = 12;
  logic       clk_sys, arst_n, clk_en, t0f, t1f, t0ck, t1ck, seen_pulse;
  logic [1:0] gate_enable, counter_select, msh, msl, run_control;
  logic [1:0] count_pin, gating_interrupt_pin, edge_req, gate_lvl;
  logic [1:0] lwr, hwr, flag_wr, flag_wr_value, vector_ack;
  logic [1:0] overflow_flag, timer_irq;
  logic [7:0] wr_data, tl0, th0, tl1, th1, r;
  logic       pulse1, pin0, pin1;
  int         err_count, checks_done, cyc, n;

  dual_timer_counter_clockout #(.PRESCALE(PRE)) DUT (
    .clk_sys, .arst_n, .clk_en, .gate_enable, .counter_select,
    .mode_select_high(msh), .mode_select_low(msl), .run_control,
    .timer0_fast_clock_select(t0f), .timer1_fast_clock_select(t1f),
    .timer0_clockout_enable(t0ck), .timer1_clockout_enable(t1ck),
    .count_pin, .gating_interrupt_pin, .wr_data, .count_low_byte_wr(lwr),
    .count_high_byte_reload_wr(hwr), .flag_wr, .flag_wr_value, .vector_ack,
    .timer0_low_byte(tl0), .timer0_high_byte(th0), .timer1_low_byte(tl1),
    .timer1_high_byte(th1), .overflow_flag, .timer_irq,
    .timer1_overflow_pulse(pulse1), .timer0_clockout_pin(pin0),
    .timer1_clockout_pin(pin1)
  );
  pin_model u_pins (.clk_sys, .edge_req, .gate_lvl, .count_pin,
    .gating_interrupt_pin);

  // ==========================================================
  // Clock, timeout and pulse watch
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (pulse1 === 1'b1) seen_pulse = 1'b1;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================
  // Access tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic mode(input int t, input logic [1:0] m);
    msh[t] = m[1];
    msl[t] = m[0];
  endtask
  task automatic wr(input int t, input logic hi, input logic [7:0] v);
    wr_data = v;
    if (hi) hwr[t] = 1'b1; else lwr[t] = 1'b1;
    tick(1);
    if (hi) hwr[t] = 1'b0; else lwr[t] = 1'b0;
  endtask
  task automatic ack(input int t);
    vector_ack[t] = 1'b1;
    tick(1);
    vector_ack = 2'h0;
  endtask
  task automatic wait_flag(input int t);
    for (int k = 0; k < 3000 && overflow_flag[t] !== 1'b1; k++) tick(1);
  endtask
  task automatic gap(output int g);
    logic [1:0] p;
    p = {pin0, pin1};
    g = 0;
    while ({pin0, pin1} === p && g < 1000) begin
      tick(1);
      g++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    {clk_en, t0f, t1f, t0ck, t1ck, seen_pulse} = '0;
    {gate_enable, counter_select, msh, msl, run_control} = '0;
    {edge_req, lwr, hwr, flag_wr, flag_wr_value, vector_ack} = '0;
    gate_lvl = 2'h3;
    wr_data = 8'h00;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    arst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    clk_en = 1'b1;
    `CHK("reset", 38'h0, {tl0, th0, tl1, th1, overflow_flag, timer_irq,
      pin0, pin1})
    // 16-bit fast count, carry, flag, vectoring and software flag access
    mode(0, timer_pkg::MODE_16BIT);
    t0f = 1'b1;
    wr(0, 1, 8'hff);
    wr(0, 0, 8'hfd);
    run_control[0] = 1'b1;
    wait_flag(0);
    run_control[0] = 1'b0;
    `CHK("carry", 8'h00, th0)
    tick(3);
    `CHK("irq", 1'b1, timer_irq[0])
    ack(0);
    `CHK("ack", 1'b0, overflow_flag[0])
    flag_wr = 2'h1;
    flag_wr_value = 2'h1;
    tick(1);
    flag_wr_value = 2'h0;
    `CHK("sw_set", 1'b1, overflow_flag[0])
    tick(1);
    flag_wr = 2'h0;
    `CHK("sw_clr", 1'b0, overflow_flag[0])
    // Slow rate: one step per PRE clocks
    t0f = 1'b0;
    wr(0, 0, 8'h00);
    run_control[0] = 1'b1;
    tick(10 * PRE);
    run_control[0] = 1'b0;
    tick(3);
    `CHK("slow", 8'h0a, tl0)
    // Gating
    t0f = 1'b1;
    gate_lvl[0] = 1'b0;
    wr(0, 0, 8'h00);
    gate_enable[0] = 1'b1;
    run_control[0] = 1'b1;
    tick(20);
    `CHK("gated", 8'h00, tl0)
    gate_lvl[0] = 1'b1;
    tick(10);
    gate_lvl[0] = 1'b0;
    tick(5);
    `CHK("gate_open", 8'h0a, tl0)
    {run_control[0], gate_enable[0]} = 2'h0;
    gate_lvl[0] = 1'b1;
    // Counter function: five falling edges on the count pin
    counter_select[0] = 1'b1;
    wr(0, 0, 8'h00);
    run_control[0] = 1'b1;
    repeat (5) begin
      edge_req[0] = 1'b1;
      tick(1);
      edge_req[0] = 1'b0;
      tick(7);
    end
    run_control[0] = 1'b0;
    tick(3);
    `CHK("events", 8'h05, tl0)
    counter_select[0] = 1'b0;
    // Mode 0: 13-bit rollover keeps the unused low bits
    mode(0, timer_pkg::MODE_13BIT);
    wr(0, 1, 8'hff);
    wr(0, 0, 8'hfd);
    run_control[0] = 1'b1;
    wait_flag(0);
    run_control[0] = 1'b0;
    tick(3);
    `CHK("m0_hi", 8'h00, th0)
    `CHK("m0_top", 3'h7, tl0[7:5])
    ack(0);
    // Mode 2 reload
    mode(0, timer_pkg::MODE_RELOAD8);
    wr(0, 1, 8'hf0);
    wr(0, 0, 8'hfe);
    run_control[0] = 1'b1;
    wait_flag(0);
    run_control[0] = 1'b0;
    tick(3);
    `CHK("rl_hi", 8'hf0, th0)
    `CHK("rl_lo", 4'hf, tl0[7:4])
    ack(0);
    // Clock-out on timer 1 at both rates
    mode(1, timer_pkg::MODE_RELOAD8);
    for (int k = 0; k < 2; k++) begin
      t1f = (k == 0);
      r = (k == 0) ? 8'hfc : 8'hfe;
      t1ck = 1'b1;
      counter_select[1] = 1'b0;
      wr(1, 1, r);
      wr(1, 0, r);
      run_control[1] = 1'b1;
      gap(n);
      gap(n);
      `CHK("cko_half", (k == 0 ? 1 : PRE) * (256 - int'(r)), n)
      `CHK("cko_flag", 1'b1, overflow_flag[1])
      `CHK("cko_irq", 1'b0, timer_irq[1])
      `CHK("cko_pulse", 1'b1, seen_pulse)
      {run_control[1], t1ck, seen_pulse} = 3'h0;
      ack(1);
    end
    // Timer 1 in mode 3 holds
    mode(1, timer_pkg::MODE_SPLIT);
    wr(1, 0, 8'h33);
    run_control[1] = 1'b1;
    tick(20);
    `CHK("t1_hold", 8'h33, tl1)
    // Timer 0 split: high byte times on run of timer 1
    mode(0, timer_pkg::MODE_SPLIT);
    counter_select[0] = 1'b1;
    wr(0, 0, 8'h44);
    wr(0, 1, 8'hf8);
    wait_flag(1);
    run_control[1] = 1'b0;
    `CHK("split_f1", 1'b1, overflow_flag[1])
    `CHK("split_f0", 1'b0, overflow_flag[0])
    `CHK("split_lo", 8'h44, tl0)
    counter_select[0] = 1'b0;
    wr(0, 0, 8'hfe);
    run_control[0] = 1'b1;
    wait_flag(0);
    run_control[0] = 1'b0;
    tick(3);
    `CHK("split_wrap", 4'h0, tl0[7:4])
    // Timer 0 clock-out overrides split mode
    t0ck = 1'b1;
    wr(0, 1, 8'hfe);
    wr(0, 0, 8'hfe);
    run_control[0] = 1'b1;
    gap(n);
    gap(n);
    `CHK("cko0_half", 256 - 8'hfe, n)
    end_sim();
  end
endmodule
